// ==== bench/escape_sequence_display_interpreter_tb_top.sv ====
// Testbench: escape sequences in, mode and read-back registers checked
`timescale 1ns/1ps
`default_nettype none
module escape_sequence_display_interpreter_tb_top;
  logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, hung;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdd, d, e;
  logic [3:0] ws;
  logic [1:0] bre, rre, r;
  int fails, n_checks;
  logic [7:0] on_c[6], off_c[6], rb_c[3], ids[3];
  esdi_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bre),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr));
  esdi_host u_host (.aclk(aclk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
    .wvalid(wv), .wready(wr_), .bresp(bre), .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv),
    .arready(arr), .rdata(rdd), .rresp(rre), .rvalid(rv), .rready(rr), .hung(hung));
  // Clock at 200 MHz
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Compare, count, report
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", w, x, s);
    end
  endtask : chk
  task automatic give_verdict();
    if (hung) fails++;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic put(input logic [7:0] b);
    u_host.wr(esdi_pkg::A_CHAR, {24'h0, b}, r);
    if (hung) give_verdict();
  endtask : put
  task automatic esc(input logic [7:0] c);
    put(esdi_pkg::ESC_CODE);
    put(c);
  endtask : esc
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string w);
    u_host.rd(a, d, r);
    if (hung) give_verdict();
    else chk(w, d & m, x);
  endtask : rchk
  // Main sequence
  initial begin
    fails = 0; n_checks = 0; aresetn = 1'b0;
    on_c = '{esdi_pkg::K_HI_ON, esdi_pkg::K_UL_ON, esdi_pkg::K_RV_ON, esdi_pkg::K_GFX_ON,
             esdi_pkg::K_WRAP_ON, esdi_pkg::K_KBD_OFF};
    off_c = '{esdi_pkg::K_HI_OFF, esdi_pkg::K_UL_OFF, esdi_pkg::K_RV_OFF, esdi_pkg::K_GFX_OFF,
              esdi_pkg::K_WRAP_OFF, esdi_pkg::K_KBD_ON};
    rb_c = '{esdi_pkg::K_AT_CURSOR, esdi_pkg::K_STATUS, esdi_pkg::K_PAGE};
    ids = '{esdi_pkg::ID_BYTE0, esdi_pkg::ID_BYTE1, esdi_pkg::ID_BYTE2};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(esdi_pkg::A_MODE, 32'hffffffff, 32'h0, "mode at reset");
    // Each mode switched on in turn, accumulating
    e = 32'h0;
    for (int i = 0; i < 6; i++) begin
      esc(on_c[i]);
      e[i] = 1'b1;
      rchk(esdi_pkg::A_MODE, 32'h3f, e, "mode on");
    end
    // Ignored and unknown sequences leave every mode alone
    esc(esdi_pkg::K_KP_ON); esc(esdi_pkg::K_KP_OFF); esc(esdi_pkg::K_ALT_ON); esc(esdi_pkg::K_ALT_OFF);
    esc(esdi_pkg::K_SET_MODE); put(8'h32); esc(esdi_pkg::K_CLR_MODE); put(8'h37); esc(8'h26);
    rchk(esdi_pkg::A_MODE, 32'h7f, 32'h3f, "mode after ignored");
    for (int i = 0; i < 6; i++) begin
      esc(off_c[i]);
      e[i] = 1'b0;
      rchk(esdi_pkg::A_MODE, 32'h3f, e, "mode off");
    end
    $display("test modes done");
    // Literal mode lasts one character
    esc(esdi_pkg::K_LITERAL);
    rchk(esdi_pkg::A_MODE, 32'h40, 32'h40, "literal pending");
    put(8'h07);
    rchk(esdi_pkg::A_MODE, 32'h40, 32'h0, "literal used");
    rchk(esdi_pkg::A_OUT, 32'h1fff, 32'h0807, "literal glyph");
    // Graphics maps the top codes down, high intensity marks the glyph
    esc(esdi_pkg::K_GFX_ON);
    esc(esdi_pkg::K_HI_ON);
    put(esdi_pkg::GFX_LO + 8'h03);
    rchk(esdi_pkg::A_OUT, 32'h1fff, 32'h1103, "graphics glyph");
    esc(esdi_pkg::K_GFX_OFF);
    esc(esdi_pkg::K_HI_OFF);
    // Cursor addressing at the last column, then wrap off and on
    u_host.cursor(8'd3, 8'd79);
    rchk(esdi_pkg::A_CURSOR, 32'h001f007f, 32'h0003004f, "cursor set");
    put(8'h41);
    rchk(esdi_pkg::A_CURSOR, 32'h001f007f, 32'h0003004f, "no wrap");
    esc(esdi_pkg::K_WRAP_ON);
    put(8'h42);
    rchk(esdi_pkg::A_CURSOR, 32'h001f007f, 32'h00040000, "wrap");
    u_host.cursor(8'd24, 8'd0);
    rchk(esdi_pkg::A_CURSOR, 32'h001f007f, 32'h00040000, "line out of range");
    esc(esdi_pkg::K_HI_ON); esc(esdi_pkg::K_RESET);
    rchk(esdi_pkg::A_MODE, 32'h7f, 32'h0, "reset modes");
    rchk(esdi_pkg::A_CURSOR, 32'h001f007f, 32'h0, "reset home");
    $display("test cursor done");
    // Key remap at the top key number, then a bad shift aborts
    esc(esdi_pkg::K_REMAP); put(8'h02); put(8'h7f); put(8'h5c);
    rchk(esdi_pkg::A_REMAP, 32'h0003ffff, 32'h00027f5c, "remap");
    esc(esdi_pkg::K_REMAP); put(8'h04); put(8'h10); put(8'h33);
    rchk(esdi_pkg::A_REMAP, 32'h0003ffff, 32'h00027f5c, "remap bad shift");
    for (int s = 0; s < 4; s++) begin
      esc(esdi_pkg::K_BANNER); put(esdi_pkg::BAN_LO + 8'(s));
      rchk(esdi_pkg::A_BANNER, 32'h3, 32'(s), "banner part");
    end
    for (int k = 0; k < 3; k++) begin
      esc(rb_c[k]);
      rchk(esdi_pkg::A_READ, 32'h3000, {18'h0, (k == 0 ? esdi_pkg::RB_CURSOR : k == 1 ? esdi_pkg::RB_STATUS
        : esdi_pkg::RB_PAGE), 12'h0}, "read-back kind");
    end
    // Identification reply popped byte by byte
    esc(esdi_pkg::K_IDENT);
    for (int k = 0; k < 3; k++) begin
      rchk(esdi_pkg::A_READ, 32'h100ff, {15'h0, 1'b1, 8'h0, ids[k]}, "ident byte");
      u_host.wr(esdi_pkg::A_READ, 32'h0, r);
    end
    rchk(esdi_pkg::A_READ, 32'h10000, 32'h0, "ident drained");
    $display("test read-back done");
    // Unmapped place refused both ways
    u_host.rd(8'h1c, d, r);
    chk("unmapped read resp", {30'h0, r}, {30'h0, esdi_pkg::RESP_SLVERR});
    chk("unmapped read data", d, 32'h0);
    u_host.wr(8'h1c, 32'h1, r);
    chk("unmapped write resp", {30'h0, r}, {30'h0, esdi_pkg::RESP_SLVERR});
    $display("test unmapped done");
    give_verdict();
  end
endmodule : escape_sequence_display_interpreter_tb_top
`default_nettype wire

// ==== bench/esdi_chk.sv ====
// Checker: bus handshakes and register read-back of the interpreter
`timescale 1ns/1ps
`default_nettype none
module esdi_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write, and a read address, taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Answers come one edge after the request and stand until taken
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid) else $error("write not answered");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read not answered");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // No new request accepted while an answer is pending
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during answer");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  // Reads above A_OUT answer an error with zero data; mode reads answer OK with bits 31..7 zero
  a_unmapped_read: assert property (s_rd_take ##0 (s_axi_araddr > esdi_pkg::A_OUT)
    |=> s_axi_rresp == esdi_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_mode_read: assert property (
    s_rd_take ##0 (s_axi_araddr == esdi_pkg::A_MODE)
    |=> s_axi_rresp == esdi_pkg::RESP_OK && s_axi_rdata[31:7] == 25'h0) else $error("mode read malformed");
endmodule : esdi_chk
bind esdi_top esdi_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ==== bench/esdi_host.sv ====
// Host model: bus master that writes the character stream
`timescale 1ns/1ps
`default_nettype none
module esdi_host (
  input wire logic        aclk,
  output var logic [7:0]  awaddr,
  output var logic        awvalid,
  input wire logic        awready,
  output var logic [31:0] wdata,
  output var logic [3:0]  wstrb,
  output var logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  output var logic        bready,
  output var logic [7:0]  araddr,
  output var logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  output var logic        rready,
  output var logic        hung
);
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
  end
  // One write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    r = bresp;
    bready <= 1'b0;
    if (!bvalid) hung = 1'b1;
  endtask : wr
  // One read, rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (!rvalid) hung = 1'b1;
  endtask : rd
  // Cursor addressing: escape, Y, line byte, column byte, zero-based offset
  task automatic cursor(input logic [7:0] line, input logic [7:0] col);
    logic [1:0] r;
    wr(esdi_pkg::A_CHAR, 32'h1b, r);
    wr(esdi_pkg::A_CHAR, 32'h59, r);
    wr(esdi_pkg::A_CHAR, {24'h0, line + esdi_pkg::COORD_OFF}, r);
    wr(esdi_pkg::A_CHAR, {24'h0, col + esdi_pkg::COORD_OFF}, r);
  endtask : cursor
endmodule : esdi_host
`default_nettype wire

// ==== logic/esdi_pkg.sv ====
// Package: constants for the escape sequence display interpreter
package esdi_pkg;
  // Character codes
  localparam logic [7:0] ESC_CODE      = 8'h1b;
  localparam logic [7:0] K_HI_ON       = 8'h28;
  localparam logic [7:0] K_HI_OFF      = 8'h29;
  localparam logic [7:0] K_UL_ON       = 8'h30;
  localparam logic [7:0] K_UL_OFF      = 8'h31;
  localparam logic [7:0] K_RV_ON       = 8'h70;
  localparam logic [7:0] K_RV_OFF      = 8'h71;
  localparam logic [7:0] K_PAGE        = 8'h23;
  localparam logic [7:0] K_AT_CURSOR   = 8'h24;
  localparam logic [7:0] K_CLR_HI      = 8'h2b;
  localparam logic [7:0] K_REMAP       = 8'h34;
  localparam logic [7:0] K_LITERAL     = 8'h38;
  localparam logic [7:0] K_GFX_ON      = 8'h46;
  localparam logic [7:0] K_GFX_OFF     = 8'h47;
  localparam logic [7:0] K_IDENT       = 8'h5a;
  localparam logic [7:0] K_STATUS      = 8'h5d;
  localparam logic [7:0] K_WRAP_ON     = 8'h76;
  localparam logic [7:0] K_WRAP_OFF    = 8'h77;
  localparam logic [7:0] K_RESET       = 8'h7a;
  localparam logic [7:0] K_KBD_ON      = 8'h7b;
  localparam logic [7:0] K_KBD_OFF     = 8'h7d;
  localparam logic [7:0] K_BANNER      = 8'h69;
  localparam logic [7:0] K_CURSOR      = 8'h59;
  localparam logic [7:0] K_SET_MODE    = 8'h78;
  localparam logic [7:0] K_CLR_MODE    = 8'h79;
  localparam logic [7:0] K_KP_ON       = 8'h74;
  localparam logic [7:0] K_KP_OFF      = 8'h75;
  localparam logic [7:0] K_ALT_ON      = 8'h3d;
  localparam logic [7:0] K_ALT_OFF     = 8'h3e;
  localparam logic [7:0] CTRL_LO       = 8'h01;
  localparam logic [7:0] CTRL_HI       = 8'h1f;
  localparam logic [7:0] GFX_LO        = 8'h5e;
  localparam logic [7:0] GFX_HI        = 8'h7f;
  localparam logic [7:0] KEY_MAX       = 8'h7f;
  localparam logic [7:0] BAN_LO        = 8'h30;
  localparam logic [7:0] BAN_HI        = 8'h33;
  localparam logic [7:0] SHIFT_LO      = 8'h01;
  localparam logic [7:0] SHIFT_HI      = 8'h03;
  localparam logic [7:0] COORD_OFF     = 8'h20;
  localparam logic [6:0] LAST_COL      = 7'h4f;
  localparam logic [4:0] LAST_LINE     = 5'h17;
  // Identification reply, arbitrary value
  localparam logic [7:0] ID_BYTE0      = 8'h1b;
  localparam logic [7:0] ID_BYTE1      = 8'h2f;
  localparam logic [7:0] ID_BYTE2      = 8'h41;
  localparam logic [1:0] ID_LEN_M1     = 2'h2;
  // Read-back kinds
  localparam logic [1:0] RB_PAGE       = 2'h0;
  localparam logic [1:0] RB_CURSOR     = 2'h1;
  localparam logic [1:0] RB_STATUS     = 2'h2;
  // Register byte offsets
  localparam logic [7:0] A_CHAR        = 8'h00;
  localparam logic [7:0] A_MODE        = 8'h04;
  localparam logic [7:0] A_CURSOR      = 8'h08;
  localparam logic [7:0] A_REMAP       = 8'h0c;
  localparam logic [7:0] A_BANNER      = 8'h10;
  localparam logic [7:0] A_READ        = 8'h14;
  localparam logic [7:0] A_OUT         = 8'h18;
  // Mode register bit positions
  localparam int M_HI   = 0;
  localparam int M_UL   = 1;
  localparam int M_RV   = 2;
  localparam int M_GFX  = 3;
  localparam int M_WRAP = 4;
  localparam int M_LOCK = 5;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {S_TEXT, S_ESC, S_LINE, S_COL, S_SHIFT, S_KEY, S_CODE, S_SEL} esdi_state_t;
endpackage : esdi_pkg

// ==== logic/esdi_top.sv ====
// Escape sequence interpreter with an AXI4-Lite register slave
// How it works
// - ESC 0x28 turns high intensity on for later characters
// - ESC 0x29 turns high intensity off
// - ESC 0x30 starts underline, ESC 0x31 ends it
// - ESC 0x70 starts reverse video, ESC 0x71 ends it
// - ESC 0x23 requests read-back of the whole page
// - ESC 0x24 requests read-back of the cursor character
// - ESC 0x2B pulses a request to clear high intensity characters
// - ESC 0x34 shift key code remaps one key, if fields are in range
// - ESC 0x38 shows next character literally, control codes as glyphs
// - ESC F maps codes 94 to 127 to glyphs 0 to 33; ESC G ends it
// - ESC 0x5A queues a fixed identification reply
// - ESC 0x5D requests read-back of the status line
// - With wrap on, column 80 overflow goes to next line column 1, on line 24 it stays on line 24
// - ESC 0x7A clears modes, clears screen and homes cursor
// - ESC 0x7D locks keyboard until ESC 0x7B
// - ESC 0x69 with selector 0x30 to 0x33 shows a banner part
// - Key click, keypad shift and alternate keypad sequences are ignored
// - One-based cursor bytes carry an offset of 0x1F
// - Zero-based cursor bytes carry an offset of 0x20
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module esdi_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  esdi_pkg::esdi_state_t st_q;
  logic [5:0]  mode_q;
  logic        lit_q;
  logic [4:0]  line_q;
  logic [6:0]  col_q;
  logic [7:0]  lbyte_q;
  logic [1:0]  shift_q;
  logic [6:0]  key_q;
  logic [23:0] remap_q;
  logic        remap_ev_q;
  logic [2:0]  banner_q;
  logic [3:0]  rb_q;
  logic        clr_scr_q;
  logic        clr_hi_q;
  logic [7:0]  out_q;
  logic [4:0]  out_attr_q;
  logic        out_v_q;
  logic        bell_q;
  logic [1:0]  id_cnt_q;
  logic        id_v_q;
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  logic        ws0_q;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Address and data taken in either order; response after both
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire [7:0]  wa   = aw_hs ? s_axi_awaddr : awa_q;
  wire [31:0] wdat = w_hs ? s_axi_wdata : wd_q;
  // Byte strobe kept with the data, the master may drop it once taken
  wire wst0   = w_hs ? s_axi_wstrb[0] : ws0_q;
  wire wr_go  = (aw_q || aw_hs) && (w_q || w_hs) && !s_axi_bvalid;
  wire wr_ok  = wa == esdi_pkg::A_CHAR || wa == esdi_pkg::A_READ;
  wire ch_go  = wr_go && wa == esdi_pkg::A_CHAR && wst0;
  wire rd_pop = wr_go && wa == esdi_pkg::A_READ && wst0;
  // Ready flags registered: free next cycle unless an item or an answer is held
  wire b_held   = s_axi_bvalid && !s_axi_bready;
  wire aw_rdy_d = !wr_go && !(aw_q || aw_hs) && !b_held;
  wire w_rdy_d  = !wr_go && !(w_q || w_hs) && !b_held;
  wire [7:0] ch = wdat[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws0_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= esdi_pkg::RESP_OK;
    end else begin
      s_axi_awready <= aw_rdy_d;
      s_axi_wready <= w_rdy_d;
      if (aw_hs) awa_q <= s_axi_awaddr;
      if (w_hs) wd_q <= s_axi_wdata;
      if (w_hs) ws0_q <= s_axi_wstrb[0];
      aw_q <= wr_go ? 1'b0 : (aw_q || aw_hs);
      w_q <= wr_go ? 1'b0 : (w_q || w_hs);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? esdi_pkg::RESP_OK : esdi_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoding of the byte stream
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    in_rng = v >= lo && v <= hi;
  endfunction : in_rng

  wire is_ctrl   = in_rng(ch, esdi_pkg::CTRL_LO, esdi_pkg::CTRL_HI);
  wire is_gfx    = mode_q[esdi_pkg::M_GFX] && in_rng(ch, esdi_pkg::GFX_LO, esdi_pkg::GFX_HI);
  wire txt_esc   = st_q == esdi_pkg::S_TEXT && !lit_q && ch == esdi_pkg::ESC_CODE;
  // Literal shows control codes as glyphs; graphics remaps 94..127
  wire txt_print = st_q == esdi_pkg::S_TEXT && (lit_q || !is_ctrl);
  wire [7:0] glyph = is_gfx ? (ch - esdi_pkg::GFX_LO) : ch;
  wire at_end    = col_q == esdi_pkg::LAST_COL;
  wire esc_st    = st_q == esdi_pkg::S_ESC;
  wire line_ok   = lbyte_q >= esdi_pkg::COORD_OFF
                   && (lbyte_q - esdi_pkg::COORD_OFF) <= {3'h0, esdi_pkg::LAST_LINE};
  wire col_ok    = ch >= esdi_pkg::COORD_OFF && (ch - esdi_pkg::COORD_OFF) <= {1'b0, esdi_pkg::LAST_COL};
  wire [7:0] lrel = lbyte_q - esdi_pkg::COORD_OFF;
  wire [7:0] crel = ch - esdi_pkg::COORD_OFF;

  // Parser state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= esdi_pkg::S_TEXT;
      lit_q <= 1'b0;
      mode_q <= 6'h00;
      line_q <= 5'h00;
      col_q <= 7'h00;
      lbyte_q <= 8'h00;
      shift_q <= 2'h0;
      key_q <= 7'h00;
      remap_q <= 24'h000000;
      remap_ev_q <= 1'b0;
      banner_q <= 3'h0;
      rb_q <= 4'h0;
      clr_scr_q <= 1'b0;
      clr_hi_q <= 1'b0;
      out_q <= 8'h00;
      out_attr_q <= 5'h00;
      out_v_q <= 1'b0;
      bell_q <= 1'b0;
      id_v_q <= 1'b0;
      id_cnt_q <= 2'h0;
    end else begin
      out_v_q <= 1'b0;
      bell_q <= 1'b0;
      clr_hi_q <= 1'b0;
      clr_scr_q <= 1'b0;
      remap_ev_q <= 1'b0;
      rb_q[3] <= 1'b0;
      banner_q[2] <= 1'b0;
      // Identification reply pops one byte per read-back pop
      if (rd_pop && id_v_q) begin
        if (id_cnt_q == esdi_pkg::ID_LEN_M1) id_v_q <= 1'b0;
        id_cnt_q <= id_cnt_q + 2'h1;
      end
      if (ch_go) begin
        case (st_q)
          esdi_pkg::S_TEXT: begin
            if (txt_esc) begin
              st_q <= esdi_pkg::S_ESC;
            end else if (txt_print) begin
              out_q <= glyph;
              out_attr_q <= {mode_q[esdi_pkg::M_GFX] && is_gfx, lit_q, mode_q[2:0]};
              out_v_q <= 1'b1;
              lit_q <= 1'b0;
              if (!at_end) begin
                col_q <= col_q + 7'h01;
              end else if (mode_q[esdi_pkg::M_WRAP]) begin
                col_q <= 7'h00;
                line_q <= (line_q == esdi_pkg::LAST_LINE) ? line_q : line_q + 5'h01;
              end
            end else begin
              bell_q <= ch == 8'h07;
            end
          end
          esdi_pkg::S_ESC: begin
            st_q <= esdi_pkg::S_TEXT;
            case (ch)
              esdi_pkg::K_HI_ON:     mode_q[esdi_pkg::M_HI] <= 1'b1;
              esdi_pkg::K_HI_OFF:    mode_q[esdi_pkg::M_HI] <= 1'b0;
              esdi_pkg::K_UL_ON:     mode_q[esdi_pkg::M_UL] <= 1'b1;
              esdi_pkg::K_UL_OFF:    mode_q[esdi_pkg::M_UL] <= 1'b0;
              esdi_pkg::K_RV_ON:     mode_q[esdi_pkg::M_RV] <= 1'b1;
              esdi_pkg::K_RV_OFF:    mode_q[esdi_pkg::M_RV] <= 1'b0;
              esdi_pkg::K_GFX_ON:    mode_q[esdi_pkg::M_GFX] <= 1'b1;
              esdi_pkg::K_GFX_OFF:   mode_q[esdi_pkg::M_GFX] <= 1'b0;
              esdi_pkg::K_WRAP_ON:   mode_q[esdi_pkg::M_WRAP] <= 1'b1;
              esdi_pkg::K_WRAP_OFF:  mode_q[esdi_pkg::M_WRAP] <= 1'b0;
              esdi_pkg::K_KBD_OFF:   mode_q[esdi_pkg::M_LOCK] <= 1'b1;
              esdi_pkg::K_KBD_ON:    mode_q[esdi_pkg::M_LOCK] <= 1'b0;
              esdi_pkg::K_PAGE:      rb_q <= {1'b1, 1'b0, esdi_pkg::RB_PAGE};
              esdi_pkg::K_AT_CURSOR: rb_q <= {1'b1, 1'b0, esdi_pkg::RB_CURSOR};
              esdi_pkg::K_STATUS:    rb_q <= {1'b1, 1'b0, esdi_pkg::RB_STATUS};
              esdi_pkg::K_CLR_HI:    clr_hi_q <= 1'b1;
              esdi_pkg::K_LITERAL:   lit_q <= 1'b1;
              esdi_pkg::K_IDENT: begin
                id_v_q <= 1'b1;
                id_cnt_q <= 2'h0;
              end
              esdi_pkg::K_RESET: begin
                mode_q <= 6'h00;
                lit_q <= 1'b0;
                line_q <= 5'h00;
                col_q <= 7'h00;
                clr_scr_q <= 1'b1;
              end
              esdi_pkg::K_CURSOR: st_q <= esdi_pkg::S_LINE;
              esdi_pkg::K_REMAP:  st_q <= esdi_pkg::S_SHIFT;
              esdi_pkg::K_BANNER: st_q <= esdi_pkg::S_SEL;
              // Parameter byte consumed and ignored
              esdi_pkg::K_SET_MODE, esdi_pkg::K_CLR_MODE: st_q <= esdi_pkg::S_SEL;
              default: st_q <= esdi_pkg::S_TEXT;
            endcase
            if (ch == esdi_pkg::K_SET_MODE || ch == esdi_pkg::K_CLR_MODE) banner_q[1:0] <= 2'h3;
            else if (ch == esdi_pkg::K_BANNER) banner_q[1:0] <= 2'h0;
          end
          esdi_pkg::S_LINE: begin
            lbyte_q <= ch;
            st_q <= esdi_pkg::S_COL;
          end
          esdi_pkg::S_COL: begin
            // Zero-based view; out of range coordinates are dropped
            if (line_ok && col_ok) begin
              line_q <= lrel[4:0];
              col_q <= crel[6:0];
            end
            st_q <= esdi_pkg::S_TEXT;
          end
          esdi_pkg::S_SHIFT: begin
            shift_q <= ch[1:0];
            key_q <= 7'h7f;
            st_q <= in_rng(ch, esdi_pkg::SHIFT_LO, esdi_pkg::SHIFT_HI) ? esdi_pkg::S_KEY : esdi_pkg::S_TEXT;
          end
          esdi_pkg::S_KEY: begin
            key_q <= ch[6:0];
            st_q <= ch <= esdi_pkg::KEY_MAX ? esdi_pkg::S_CODE : esdi_pkg::S_TEXT;
          end
          esdi_pkg::S_CODE: begin
            remap_q <= {6'h00, shift_q, 1'b0, key_q, ch};
            remap_ev_q <= 1'b1;
            st_q <= esdi_pkg::S_TEXT;
          end
          esdi_pkg::S_SEL: begin
            if (banner_q[1:0] == 2'h0 && in_rng(ch, esdi_pkg::BAN_LO, esdi_pkg::BAN_HI))
              banner_q <= {1'b1, ch[1:0]};
            st_q <= esdi_pkg::S_TEXT;
          end
          default: st_q <= esdi_pkg::S_TEXT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] id_byte = id_cnt_q == 2'h0 ? esdi_pkg::ID_BYTE0 :
                       id_cnt_q == 2'h1 ? esdi_pkg::ID_BYTE1 : esdi_pkg::ID_BYTE2;
  wire [31:0] rsel =
    s_axi_araddr == esdi_pkg::A_MODE   ? {25'h0, lit_q, mode_q} :
    s_axi_araddr == esdi_pkg::A_CURSOR ? {4'h0, st_q, 1'b0, 3'h0, line_q, 9'h0, col_q} :
    s_axi_araddr == esdi_pkg::A_REMAP  ? {7'h0, remap_ev_q, remap_q} :
    s_axi_araddr == esdi_pkg::A_BANNER ? {29'h0, banner_q} :
    s_axi_araddr == esdi_pkg::A_READ   ? {15'h0, id_v_q, rb_q, clr_hi_q, clr_scr_q, 2'h0, id_byte} :
    s_axi_araddr == esdi_pkg::A_OUT    ? {17'h0, bell_q, out_v_q, out_attr_q, out_q} : 32'h0;
  wire rd_ok = s_axi_araddr == esdi_pkg::A_MODE || s_axi_araddr == esdi_pkg::A_CURSOR
            || s_axi_araddr == esdi_pkg::A_REMAP || s_axi_araddr == esdi_pkg::A_BANNER
            || s_axi_araddr == esdi_pkg::A_READ || s_axi_araddr == esdi_pkg::A_OUT
            || s_axi_araddr == esdi_pkg::A_CHAR;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  // Read response one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= esdi_pkg::RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_hs && !s_axi_arready;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rsel;
        s_axi_rresp <= rd_ok ? esdi_pkg::RESP_OK : esdi_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : esdi_top
`default_nettype wire
